// ### src/sample_and_buffer_status_flags.sv
// Sample and buffer status flags with event pin routing behind an AXI4-Lite slave.
module sample_and_buffer_status_flags #(
	parameter int DEPTH   = 512,
	parameter int LVL_W   = 10,
	parameter int SAMPLE_W = 16
) (
	input  wire logic                clk_sys,
	input  wire logic                nrst,
	input  wire logic                clk_en,
	input  wire logic                sample_valid,
	input  wire logic [SAMPLE_W-1:0] sample_data,
	input  wire logic                activity_event,
	input  wire logic [31:0]         s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [31:0]         s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	output logic                     event_pin_a_out,
	output logic                     event_pin_a_oe,
	output logic                     event_pin_b_out,
	output logic                     event_pin_b_oe
);
	// The level counter must hold the full depth and the nine-bit watermark, and a sample must fit a bus word.
	if (DEPTH < 2 || DEPTH > (1 << LVL_W) - 1 || LVL_W < 9 || LVL_W > 16 || SAMPLE_W > 32) begin : g_bad_size
		$error("Unsupported buffer parameters.");
	end

	localparam int AW = $clog2(DEPTH);

	logic [SAMPLE_W-1:0] mem [DEPTH];
	logic [AW-1:0]       wr_ptr;
	logic [AW-1:0]       rd_ptr;
	logic [LVL_W-1:0]    count;
	logic [7:0]          wm_level;
	logic [7:0]          buffer_control;
	logic [7:0]          event_route_a;
	logic [7:0]          event_route_b;
	logic [SAMPLE_W-1:0] latest_sample;
	logic                new_sample_flag;
	logic                pending_sample;
	logic                buffer_overrun_flag;
	logic                drained_since_ovr;
	logic                triggered;
	logic [LVL_W-1:0]    post_left;
	logic                aw_held;
	logic                w_held;
	logic [7:0]          aw_off;
	logic [31:0]         w_data;
	logic [3:0]          w_strb;

	// Every register fills one aligned word, so its index is the byte address over four.
	// Addresses above the decoded window map to an index that no register uses.
	function automatic logic [7:0] word_off(input logic [31:0] addr);
		return (addr[31:10] == 22'h00_0000) ? addr[9:2] : 8'hFF;
	endfunction

	function automatic logic [7:0] merge(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
		return s[0] ? d[7:0] : old;
	endfunction

	wire status_flags_pkg::buf_mode_e mode =
		status_flags_pkg::buf_mode_e'(buffer_control[status_flags_pkg::CTL_MODE_LSB +: 2]);
	wire logic [LVL_W-1:0] wm_full = LVL_W'({buffer_control[status_flags_pkg::CTL_WM_HI], wm_level});
	wire logic buf_off      = (mode == status_flags_pkg::MODE_OFF);
	wire logic buf_full     = (count == LVL_W'(DEPTH));
	wire logic buf_empty    = (count == '0);

	// Reads are one-cycle AXI transfers, so the read window is the accepted read cycle.
	wire logic rd_take      = s_axi_arvalid && !s_axi_rvalid;
	wire logic [7:0] rd_off = word_off(s_axi_araddr);
	wire logic data_read    = rd_take && (rd_off == status_flags_pkg::OFF_DATA);
	wire logic buf_pop      = rd_take && (rd_off == status_flags_pkg::OFF_BUF_DATA) && !buf_empty && !buf_off;
	wire logic status_read  = rd_take && (rd_off == status_flags_pkg::OFF_STATUS);

	// A sample offered to a disabled buffer is dropped here, so nothing stored outlives the disable.
	wire logic accept       = sample_valid && !buf_off;
	wire logic stop_oldest  = (mode == status_flags_pkg::MODE_OLDEST) && buf_full;
	wire logic stop_trig    = (mode == status_flags_pkg::MODE_TRIG) && triggered && (post_left == '0);
	wire logic store        = accept && !stop_oldest && !stop_trig;
	wire logic displace     = store && buf_full && !buf_pop;
	wire logic ovr_event    = displace || (accept && stop_oldest);

	wire logic flag_watermark = buf_off ? 1'b0 : (count >= wm_full);
	wire logic flag_ready     = !buf_empty && !buf_off &&
		((mode != status_flags_pkg::MODE_TRIG) || (triggered && post_left == '0));
	wire logic [7:0] status_word = {4'h0, buffer_overrun_flag, flag_watermark, flag_ready, new_sample_flag};

	// Address and data may come in either order; the one that arrives first is parked until its partner shows up.
	wire logic wr_fire    = (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid) && !s_axi_bvalid;
	wire logic [7:0] wr_off = aw_held ? aw_off : word_off(s_axi_awaddr);
	wire logic [31:0] wr_d  = w_held ? w_data : s_axi_wdata;
	wire logic [3:0]  wr_s  = w_held ? w_strb : s_axi_wstrb;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	wire logic rd_known = (rd_off == status_flags_pkg::OFF_STATUS) || (rd_off == status_flags_pkg::OFF_WM_LEVEL) ||
		(rd_off == status_flags_pkg::OFF_BUF_CTL) || (rd_off == status_flags_pkg::OFF_ROUTE_A) ||
		(rd_off == status_flags_pkg::OFF_ROUTE_B) || (rd_off == status_flags_pkg::OFF_DATA) ||
		(rd_off == status_flags_pkg::OFF_BUF_DATA) || (rd_off == status_flags_pkg::OFF_LEVEL);
	wire logic [31:0] rd_mux =
		(rd_off == status_flags_pkg::OFF_STATUS)   ? {24'h00_0000, status_word} :
		(rd_off == status_flags_pkg::OFF_WM_LEVEL) ? {24'h00_0000, wm_level} :
		(rd_off == status_flags_pkg::OFF_BUF_CTL)  ? {24'h00_0000, buffer_control} :
		(rd_off == status_flags_pkg::OFF_ROUTE_A)  ? {24'h00_0000, event_route_a} :
		(rd_off == status_flags_pkg::OFF_ROUTE_B)  ? {24'h00_0000, event_route_b} :
		(rd_off == status_flags_pkg::OFF_DATA)     ? 32'(latest_sample) :
		(rd_off == status_flags_pkg::OFF_BUF_DATA) ? (buf_pop ? 32'(mem[rd_ptr]) : 32'h0000_0000) :
		(rd_off == status_flags_pkg::OFF_LEVEL)    ? 32'(count) : 32'h0000_0000;

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= status_flags_pkg::RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= status_flags_pkg::RESP_OKAY;
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_off       <= 8'h00;
			w_data       <= 32'h0000_0000;
			w_strb       <= 4'h0;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready && !wr_fire) begin
				aw_held <= 1'b1;
				aw_off  <= word_off(s_axi_awaddr);
			end
			if (s_axi_wvalid && s_axi_wready && !wr_fire) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_off == status_flags_pkg::OFF_WM_LEVEL || wr_off == status_flags_pkg::OFF_BUF_CTL ||
					wr_off == status_flags_pkg::OFF_ROUTE_A || wr_off == status_flags_pkg::OFF_ROUTE_B) ?
					status_flags_pkg::RESP_OKAY : status_flags_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (rd_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_mux;
				s_axi_rresp  <= rd_known ? status_flags_pkg::RESP_OKAY : status_flags_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			wm_level       <= status_flags_pkg::WM_LEVEL_RESET;
			buffer_control <= status_flags_pkg::BUF_CTL_RESET;
			event_route_a  <= status_flags_pkg::ROUTE_RESET;
			event_route_b  <= status_flags_pkg::ROUTE_RESET;
		end else if (clk_en && wr_fire) begin
			if (wr_off == status_flags_pkg::OFF_WM_LEVEL)
				wm_level <= merge(wm_level, wr_d, wr_s);
			if (wr_off == status_flags_pkg::OFF_BUF_CTL)
				buffer_control <= merge(buffer_control, wr_d, wr_s) & 8'h07;
			if (wr_off == status_flags_pkg::OFF_ROUTE_A)
				event_route_a <= merge(event_route_a, wr_d, wr_s) & 8'h8F;
			if (wr_off == status_flags_pkg::OFF_ROUTE_B)
				event_route_b <= merge(event_route_b, wr_d, wr_s) & 8'h8F;
		end
	end

	// New-sample flag: a sample landing in a data read is not latched; only its flag is parked and set once the read ends.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			new_sample_flag <= 1'b0;
			pending_sample  <= 1'b0;
			latest_sample   <= '0;
		end else if (clk_en) begin
			if (sample_valid && !data_read)
				latest_sample <= sample_data;
			if (data_read) begin
				new_sample_flag <= 1'b0;
				pending_sample  <= pending_sample || sample_valid;
			end else begin
				new_sample_flag <= new_sample_flag || sample_valid || pending_sample;
				pending_sample  <= 1'b0;
			end
		end
	end

	// The memory has no reset, so its writes wait for reset and follow the clock enable like all other state.
	always_ff @(posedge clk_sys) begin
		if (nrst && clk_en && store)
			mem[wr_ptr] <= sample_data;
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			count     <= '0;
			triggered <= 1'b0;
			post_left <= '0;
		end else if (clk_en) begin
			if (buf_off) begin
				wr_ptr    <= '0;
				rd_ptr    <= '0;
				count     <= '0;
				triggered <= 1'b0;
				post_left <= '0;
			end else begin
				if (store)
					wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
				if (buf_pop || displace)
					rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
				if (store && !buf_full && !buf_pop)
					count <= count + 1'b1;
				else if (buf_pop && !store)
					count <= count - 1'b1;
				if (mode == status_flags_pkg::MODE_TRIG && !triggered && activity_event) begin
					triggered <= 1'b1;
					post_left <= wm_full;
				end else if (triggered && store && post_left != '0) begin
					post_left <= post_left - 1'b1;
				end
			end
		end
	end

	// Overrun clears on a disable of the buffer, or else needs both a drained buffer and a later status read; a new overrun wins over the clear.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			buffer_overrun_flag <= 1'b0;
			drained_since_ovr   <= 1'b0;
		end else if (clk_en) begin
			if (buf_off) begin
				buffer_overrun_flag <= 1'b0;
				drained_since_ovr   <= 1'b0;
			end else if (ovr_event) begin
				buffer_overrun_flag <= 1'b1;
				drained_since_ovr   <= 1'b0;
			end else if (buffer_overrun_flag) begin
				if (status_read && (drained_since_ovr || buf_empty))
					buffer_overrun_flag <= 1'b0;
				if (buf_empty)
					drained_since_ovr <= 1'b1;
			end else begin
				drained_since_ovr <= 1'b0;
			end
		end
	end

	wire logic [3:0] src = status_word[3:0];
	wire logic act_a = |(src & event_route_a[3:0]);
	wire logic act_b = |(src & event_route_b[3:0]);

	// The pins are registered so that a glitch on the combined flags never reaches the host.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			event_pin_a_out <= 1'b0;
			event_pin_a_oe  <= 1'b0;
			event_pin_b_out <= 1'b0;
			event_pin_b_oe  <= 1'b0;
		end else if (clk_en) begin
			event_pin_a_out <= act_a ^ event_route_a[status_flags_pkg::ROUTE_POL_BIT];
			event_pin_b_out <= act_b ^ event_route_b[status_flags_pkg::ROUTE_POL_BIT];
			event_pin_a_oe  <= |event_route_a[3:0];
			event_pin_b_oe  <= |event_route_b[3:0];
		end
	end
endmodule

// ### src/status_flags_pkg.sv
// Package with register map, field layout and reset values of the status flag block.
package status_flags_pkg;
	localparam logic [7:0]  OFF_STATUS      = 8'h04;
	localparam logic [7:0]  OFF_WM_LEVEL    = 8'h39;
	localparam logic [7:0]  OFF_BUF_CTL     = 8'h3A;
	localparam logic [7:0]  OFF_ROUTE_A     = 8'h3B;
	localparam logic [7:0]  OFF_ROUTE_B     = 8'h3C;
	localparam logic [7:0]  OFF_DATA        = 8'h40;
	localparam logic [7:0]  OFF_BUF_DATA    = 8'h44;
	localparam logic [7:0]  OFF_LEVEL       = 8'h48;
	localparam int          ST_NEW_SAMPLE   = 0;
	localparam int          ST_BUF_READY    = 1;
	localparam int          ST_WATERMARK    = 2;
	localparam int          ST_OVERRUN      = 3;
	localparam int          CTL_WM_HI       = 0;
	localparam int          CTL_MODE_LSB    = 1;
	localparam int          ROUTE_POL_BIT   = 7;
	localparam logic [7:0]  WM_LEVEL_RESET  = 8'h80;
	localparam logic [7:0]  BUF_CTL_RESET   = 8'h00;
	localparam logic [7:0]  ROUTE_RESET     = 8'h00;
	localparam logic [1:0]  RESP_OKAY       = 2'b00;
	localparam logic [1:0]  RESP_SLVERR     = 2'b10;
	typedef enum logic [1:0] {
		MODE_OFF    = 2'b00,
		MODE_STREAM = 2'b01,
		MODE_TRIG   = 2'b10,
		MODE_OLDEST = 2'b11
	} buf_mode_e;
endpackage

// ### test/flags_chk.sv
// Bus and pin checks bound to the status flag block.
module flags_chk (
	input wire logic        clk_sys,
	input wire logic        nrst,
	input wire logic [31:0] s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        event_pin_a_oe,
	input wire logic        event_pin_b_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);
	a_pins_reset_hiz: assert property ($rose(nrst) |-> !event_pin_a_oe && !event_pin_b_oe)
		else $error("event pin driven after reset");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
		else $error("write answer late");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	a_read_retires: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[31:10] != 22'h00_0000
		|=> s_axi_rresp == status_flags_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
		else $error("unmapped read not refused");
endmodule

bind sample_and_buffer_status_flags flags_chk u_flags_chk (.*);

// ### test/host_pin_model.sv
// Host-side model of the two event pin wires, each held by a bus keeper.
module host_pin_model (
	input  wire logic event_pin_a_out,
	input  wire logic event_pin_a_oe,
	input  wire logic event_pin_b_out,
	input  wire logic event_pin_b_oe,
	output logic      level_a,
	output logic      level_b
);
	timeunit 1ns;
	timeprecision 1ps;
	// The keeper holds the last driven level, so a released pin shows no new edge to the host.
	always_latch begin
		if (event_pin_a_oe) level_a <= event_pin_a_out;
		if (event_pin_b_oe) level_b <= event_pin_b_out;
	end
endmodule

// ### test/sample_and_buffer_status_flags_test.sv
// Self-checking bench for the sample and buffer status flag block.
module sample_and_buffer_status_flags_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys = 1'b0, nrst = 1'b0, clk_en = 1'b1, sample_valid = 1'b0, activity_event = 1'b0;
	logic [15:0] sample_data = 16'h0000;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb = 4'h1;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        event_pin_a_out, event_pin_a_oe, event_pin_b_out, event_pin_b_oe, level_a, level_b;
	int          err_count = 0, n_tests = 0, cycles = 0;
	sample_and_buffer_status_flags #(.DEPTH(8)) DUT (.*);
	host_pin_model host (.*);
	always #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_count++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		if (err_count == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	// Registers sit one per word, so the byte address is four times the offset.
	function automatic logic [31:0] adr(input logic [7:0] o);
		return {22'h00_0000, o, 2'b00};
	endfunction
	// A sample pulse can be laid on the edge that takes the read address.
	task automatic rd(input logic [31:0] a, input logic smp, output logic [31:0] q, output logic [1:0] e);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		sample_valid <= smp;
		do @(posedge clk_sys); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		sample_valid <= 1'b0;
		while (!s_axi_rvalid) @(posedge clk_sys);
		s_axi_rready <= 1'b1;
		@(posedge clk_sys);
		q = s_axi_rdata;
		e = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] o, input logic [7:0] v);
		@(posedge clk_sys);
		s_axi_awaddr <= adr(o);
		s_axi_wdata <= {24'h00_0000, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_awvalid || s_axi_wvalid);
		while (!s_axi_bvalid) @(posedge clk_sys);
		s_axi_bready <= 1'b1;
		@(posedge clk_sys);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic mode(input status_flags_pkg::buf_mode_e m, input logic hi);
		wr(status_flags_pkg::OFF_BUF_CTL, {5'h00, m, hi});
	endtask
	task automatic push(input int n);
		repeat (n) begin
			@(posedge clk_sys);
			sample_valid <= 1'b1;
			sample_data <= sample_data + 16'h0011;
			@(posedge clk_sys);
			sample_valid <= 1'b0;
		end
	endtask
	task automatic pop(input int n);
		repeat (n) rd(adr(status_flags_pkg::OFF_BUF_DATA), 1'b0, d, r);
	endtask
	task automatic st(input logic [3:0] e);
		rd(adr(status_flags_pkg::OFF_STATUS), 1'b0, d, r);
		chk("status", d, {28'h000_0000, e});
	endtask
	task automatic t_reset();
		chk("pin_oe", {event_pin_a_oe, event_pin_b_oe}, '0);
		rd(adr(status_flags_pkg::OFF_WM_LEVEL), 1'b0, d, r);
		chk("wm_level", d, 32'h0000_0080);
		st(4'h0);
		rd(32'h0000_1000, 1'b0, d, r);
		chk("rresp", r, status_flags_pkg::RESP_SLVERR);
		wr(status_flags_pkg::OFF_STATUS, 8'hFF);
		chk("bresp", r, status_flags_pkg::RESP_SLVERR);
	endtask
	task automatic t_new_sample();
		push(1);
		st(4'h1);
		rd(adr(status_flags_pkg::OFF_DATA), 1'b0, d, r);
		st(4'h0);
		rd(adr(status_flags_pkg::OFF_DATA), 1'b1, d, r);
		st(4'h1);
		rd(adr(status_flags_pkg::OFF_DATA), 1'b1, d, r);
		st(4'h1);
	endtask
	task automatic t_buffer();
		wr(status_flags_pkg::OFF_WM_LEVEL, 8'h03);
		mode(status_flags_pkg::MODE_STREAM, 1'b0);
		push(2);
		st(4'h3);
		push(1);
		st(4'h7);
		pop(1);
		st(4'h3);
		wr(status_flags_pkg::OFF_WM_LEVEL, 8'h00);
		st(4'h7);
		wr(status_flags_pkg::OFF_WM_LEVEL, 8'h03);
		mode(status_flags_pkg::MODE_STREAM, 1'b1);
		st(4'h3);
		push(7);
		st(4'hB);
		st(4'hB);
		pop(8);
		st(4'h9);
		st(4'h1);
		push(9);
		mode(status_flags_pkg::MODE_OFF, 1'b0);
		push(1);
		st(4'h1);
		rd(adr(status_flags_pkg::OFF_LEVEL), 1'b0, d, r);
		chk("count", d, '0);
	endtask
	task automatic t_modes();
		mode(status_flags_pkg::MODE_OLDEST, 1'b0);
		push(9);
		st(4'hF);
		rd(adr(status_flags_pkg::OFF_LEVEL), 1'b0, d, r);
		chk("count", d, 32'h0000_0008);
		mode(status_flags_pkg::MODE_OFF, 1'b0);
		mode(status_flags_pkg::MODE_TRIG, 1'b0);
		push(4);
		@(posedge clk_sys);
		activity_event <= 1'b1;
		@(posedge clk_sys);
		activity_event <= 1'b0;
		push(2);
		st_bit(1'b0);
		push(1);
		st_bit(1'b1);
		mode(status_flags_pkg::MODE_OFF, 1'b0);
	endtask
	task automatic st_bit(input logic e);
		rd(adr(status_flags_pkg::OFF_STATUS), 1'b0, d, r);
		chk("ready", d[status_flags_pkg::ST_BUF_READY], e);
	endtask
	task automatic pins(input logic [3:0] e);
		repeat (2) @(posedge clk_sys);
		chk("pins", {event_pin_a_oe, event_pin_a_out, event_pin_b_oe, event_pin_b_out}, e);
	endtask
	task automatic t_pins();
		rd(adr(status_flags_pkg::OFF_DATA), 1'b0, d, r);
		wr(status_flags_pkg::OFF_ROUTE_A, 8'h01);
		pins(4'h8);
		push(1);
		pins(4'hC);
		chk("level_a", level_a, 1'b1);
		wr(status_flags_pkg::OFF_ROUTE_A, 8'h81);
		pins(4'h8);
		wr(status_flags_pkg::OFF_ROUTE_B, 8'h0C);
		pins(4'hA);
		wr(status_flags_pkg::OFF_ROUTE_B, 8'h0D);
		pins(4'hB);
		wr(status_flags_pkg::OFF_ROUTE_A, 8'h00);
		pins(4'h3);
	endtask
	// Samples offered while the clock enable is low must leave every flag untouched.
	task automatic t_freeze();
		rd(adr(status_flags_pkg::OFF_DATA), 1'b0, d, r);
		@(posedge clk_sys);
		clk_en <= 1'b0;
		push(2);
		@(posedge clk_sys);
		clk_en <= 1'b1;
		st(4'h0);
	endtask
	initial begin
		repeat (5) @(posedge clk_sys);
		nrst <= 1'b1;
		t_reset();
		t_new_sample();
		t_buffer();
		t_modes();
		t_pins();
		t_freeze();
		report_and_stop();
	end
endmodule
